//--- hdl/sic_defines.svh
// Constants for the serial identifier and second tally register slice
//
// Contract
// - Serial identifier bytes accept writes only while the lock flag is low.
// - Serial identifier bytes live in storage that no reset clears.
// - Identifier byte k carries identifier bits 8k+7 down to 8k, low byte first.
// - Tally high byte holds bits 15..8, counts low-byte carries, software writable.
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH

// Register byte offsets on the register port
`define SIC_OFS_TALLY_HI 8'h10
`define SIC_OFS_SERIAL0 8'h11
`define SIC_OFS_SERIAL1 8'h12
`define SIC_OFS_SERIAL2 8'h13
`define SIC_OFS_SERIAL3 8'h14
`define SIC_OFS_SERIAL4 8'h15
`define SIC_OFS_SERIAL5 8'h16

// Storage slot indices; slot 0 is the tally byte, 1..6 the serial bytes
`define SIC_IDX_TALLY 3'h0
`define SIC_IDX_SERIAL0 3'h1
`define SIC_IDX_SERIAL1 3'h2
`define SIC_IDX_SERIAL2 3'h3
`define SIC_IDX_SERIAL3 3'h4
`define SIC_IDX_SERIAL4 3'h5
`define SIC_IDX_SERIAL5 3'h6
`define SIC_IDX_NONE 3'h7
`define SIC_NUM_SLOTS 7

// Field layout of the storage image
`define SIC_BYTE_W 8
`define SIC_IMAGE_W 56
`define SIC_ID_LSB 8
`define SIC_ID_MSB 55
`define SIC_TALLY_LSB 0
`define SIC_TALLY_MSB 7

// Values
`define SIC_RDATA_RST 8'h00
`define SIC_UNMAPPED_DATA 8'h00
`define SIC_TALLY_STEP 8'h01

`endif

//--- hdl/sic_nv_store.sv
// Persistent byte store for the tally high byte and serial identifier bytes
`timescale 1ns/1ps
`include "sic_defines.svh"
module sic_nv_store (
    input wire logic ref_clk,
    sic_store_if.store sif
);

    // No reset on purpose: contents must outlive any reset or power loss
    logic [`SIC_BYTE_W-1:0] mem [0:`SIC_NUM_SLOTS-1];

    // Carry steps tally byte
    // A software write to the tally byte wins over a carry in the same cycle
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < `SIC_NUM_SLOTS; i++) begin
            if (sif.wr_en && (sif.wr_idx == 3'(i))) begin
                mem[i] <= sif.wr_data;
            end else if (sif.inc && (3'(i) == `SIC_IDX_TALLY)) begin
                mem[i] <= mem[i] + `SIC_TALLY_STEP;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `SIC_NUM_SLOTS; g++) begin : g_image
            assign sif.image[g*`SIC_BYTE_W +: `SIC_BYTE_W] = mem[g];
        end
    endgenerate

endmodule : sic_nv_store

//--- hdl/sic_pkg.sv
// Types shared by the serial identifier register slice
package sic_pkg;

    typedef logic [7:0] sic_byte_t;
    typedef logic [2:0] sic_idx_t;
    typedef logic [55:0] sic_image_t;

    // Whole register-port state of the top module
    typedef struct packed {
        sic_byte_t rdata;
        logic ack;
        logic ignored;
    } sic_state_t;

endpackage : sic_pkg

//--- hdl/sic_regs.sv
// Register slice: serial identifier bytes 0..5 and second tally high byte
`timescale 1ns/1ps
`include "sic_defines.svh"
module sic_regs (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_ack,
    input wire logic serial_lock_flag,
    input wire logic tally_low_carry,
    output logic [47:0] identifier_bit,
    output logic [7:0] second_tally_high,
    output logic write_ignored
);

    sic_store_if sif ();

    sic_pkg::sic_state_t state_r;
    sic_pkg::sic_state_t state_nxt;
    sic_pkg::sic_idx_t sel_idx;
    logic sel_serial;

    // Map a byte offset onto a storage slot; NONE for unmapped offsets
    function automatic sic_pkg::sic_idx_t sic_decode(input logic [7:0] addr);
        sic_pkg::sic_idx_t idx;
        idx = `SIC_IDX_NONE;
        case (addr)
            `SIC_OFS_TALLY_HI: idx = `SIC_IDX_TALLY;
            `SIC_OFS_SERIAL0: idx = `SIC_IDX_SERIAL0;
            `SIC_OFS_SERIAL1: idx = `SIC_IDX_SERIAL1;
            `SIC_OFS_SERIAL2: idx = `SIC_IDX_SERIAL2;
            `SIC_OFS_SERIAL3: idx = `SIC_IDX_SERIAL3;
            `SIC_OFS_SERIAL4: idx = `SIC_IDX_SERIAL4;
            `SIC_OFS_SERIAL5: idx = `SIC_IDX_SERIAL5;
            default: idx = `SIC_IDX_NONE;
        endcase
        return idx;
    endfunction : sic_decode

    // Pick one byte out of the storage image; unmapped reads return a fixed value
    function automatic sic_pkg::sic_byte_t sic_pick(input sic_pkg::sic_image_t img,
                                                    input sic_pkg::sic_idx_t idx);
        sic_pkg::sic_byte_t b;
        b = `SIC_UNMAPPED_DATA;
        if (idx != `SIC_IDX_NONE) begin
            b = img[idx*`SIC_BYTE_W +: `SIC_BYTE_W];
        end
        return b;
    endfunction : sic_pick

    // Address decode shared by read and write paths
    assign sel_idx = sic_decode(reg_addr);
    assign sel_serial = (sel_idx != `SIC_IDX_NONE) && (sel_idx != `SIC_IDX_TALLY);

    // Write path into the store
    // Lock gates serial writes
    // The lock never gates the tally byte, only the identifier slots
    // No store write while in reset: such a write would never be acked
    assign sif.wr_en = reg_wr && !sys_rst && (sel_idx != `SIC_IDX_NONE)
                       && !(sel_serial && serial_lock_flag);
    assign sif.wr_idx = sel_idx;
    assign sif.wr_data = reg_wdata;

    // Low byte carry steps high byte
    assign sif.inc = tally_low_carry;

    // Front-end next state: every access outside reset is answered one cycle later
    always_comb begin
        state_nxt = state_r;
        state_nxt.ack = reg_wr || reg_rd;
        state_nxt.ignored = 1'b0;
        // Read returns the value held before any write in the same cycle
        if (reg_rd) begin
            state_nxt.rdata = sic_pick(sif.image, sel_idx);
        end
        if (reg_wr && sel_serial && serial_lock_flag) begin
            state_nxt.ignored = 1'b1;
        end
    end

    // State register
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= '{rdata: `SIC_RDATA_RST, ack: 1'b0, ignored: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    sic_nv_store u_store (
        .ref_clk(ref_clk),
        .sif(sif.store)
    );

    // Outputs
    assign reg_rdata = state_r.rdata;
    assign reg_ack = state_r.ack;
    assign write_ignored = state_r.ignored; // Status only; the bus sees a normal ack
    assign identifier_bit = sif.image[`SIC_ID_MSB:`SIC_ID_LSB];
    assign second_tally_high = sif.image[`SIC_TALLY_MSB:`SIC_TALLY_LSB];

endmodule : sic_regs

//--- hdl/sic_store_if.sv
// Interface between the register front end and the byte store
`timescale 1ns/1ps
interface sic_store_if;
    logic wr_en;
    sic_pkg::sic_idx_t wr_idx;
    sic_pkg::sic_byte_t wr_data;
    logic inc;
    sic_pkg::sic_image_t image;

    modport front (
        output wr_en,
        output wr_idx,
        output wr_data,
        output inc,
        input image
    );

    modport store (
        input wr_en,
        input wr_idx,
        input wr_data,
        input inc,
        output image
    );
endinterface : sic_store_if

//--- sim/sic_host_model.sv
// Host software model issuing strobe accesses
`timescale 1ns/1ps
module sic_host_model (
    input wire logic ref_clk,
    output logic [7:0] addr = 8'h00,
    output logic [7:0] wdata = 8'h00,
    output logic wr = 1'b0,
    output logic rd = 1'b0,
    input wire logic [7:0] rdata,
    input wire logic ack
);
    // One-cycle strobe; ack and data are taken while they stand
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q, output logic ok);
        @(negedge ref_clk);
        addr = a;
        wdata = d;
        wr = w;
        rd = !w;
        @(negedge ref_clk);
        wr = 1'b0;
        rd = 1'b0;
        q = rdata;
        ok = ack;
    endtask : xfer
endmodule : sic_host_model

//--- sim/sic_regs_sva.sv
// Port checker for the register slice
`timescale 1ns/1ps
module sic_regs_sva (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic reg_ack,
    input wire logic serial_lock_flag,
    input wire logic tally_low_carry,
    input wire logic [47:0] identifier_bit,
    input wire logic [7:0] second_tally_high,
    input wire logic write_ignored
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    wire logic ser = reg_wr && reg_addr inside {[8'h11:8'h16]};
    a_lock_holds: assert property (ser && serial_lock_flag |=>
        $stable(identifier_bit) && write_ignored) else $error("locked byte changed");
    a_ack_one: assert property ((reg_wr || reg_rd) |=> reg_ack) else $error("no ack");
    a_byte_zero: assert property (reg_wr && !serial_lock_flag && reg_addr == 8'h11 |=>
        identifier_bit[7:0] == $past(reg_wdata)) else $error("byte 0 wrong");
    a_tally_step: assert property (tally_low_carry && !(reg_wr && reg_addr == 8'h10) |=>
        second_tally_high == $past(second_tally_high) + 8'h01) else $error("no carry");
    a_id_keep: assert property (!reg_wr |=> $stable(identifier_bit)) else $error("id drift");
    c_locked: cover property (ser && serial_lock_flag);
    c_open: cover property (ser && !serial_lock_flag);
    c_carry: cover property (tally_low_carry);
endmodule : sic_regs_sva
bind sic_regs sic_regs_sva chk_i (.*);

//--- sim/sic_regs_tb_top.sv
// Bench for the serial identifier register slice
`timescale 1ns/1ps
module sic_regs_tb_top;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic lock = 1'b0;
    logic carry = 1'b0;
    logic [7:0] addr, wdata, rdata, tally, q;
    logic wr, rd, ack, ok, ign;
    logic [47:0] id;
    int error_cnt = 0;
    int n_tests = 0;
    int cyc = 0;
    always #12.5 ref_clk = ~ref_clk;
    sic_host_model host (.ref_clk(ref_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .ack(ack));
    sic_regs dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .reg_ack(ack), .serial_lock_flag(lock),
        .tally_low_carry(carry), .identifier_bit(id), .second_tally_high(tally),
        .write_ignored(ign));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic print_verdict();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict
    // Hang guard, well above the short sequence
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        sys_rst = 1'b0;
        // Open writes, then locked writes that must bounce
        for (int k = 0; k < 6; k++) begin
            host.xfer(1'b1, 8'h11 + k[7:0], 8'hA0 + k[7:0], q, ok);
            chk(id[8*k +: 8], 8'hA0 + k[7:0]);
            chk({7'h00, ign}, 8'h00);
        end
        lock = 1'b1;
        for (int k = 0; k < 6; k++) begin
            host.xfer(1'b1, 8'h11 + k[7:0], 8'h5A, q, ok);
            chk({7'h00, ok}, 8'h01);
            chk({7'h00, ign}, 8'h01);
            host.xfer(1'b0, 8'h11 + k[7:0], 8'h00, q, ok);
            chk(q, 8'hA0 + k[7:0]);
        end
        // Second reset must not clear storage
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk(id[47:40], 8'hA5);
        // Tally wraps from FF, lock has no say over it
        host.xfer(1'b1, 8'h10, 8'hFF, q, ok);
        repeat (2) begin
            @(negedge ref_clk);
            carry = 1'b1;
            @(negedge ref_clk);
            carry = 1'b0;
        end
        host.xfer(1'b0, 8'h10, 8'h00, q, ok);
        chk(q, 8'h01);
        chk(tally, 8'h01);
        host.xfer(1'b0, 8'h20, 8'h00, q, ok);
        chk(q, 8'h00);
        print_verdict();
    end
endmodule : sic_regs_tb_top
